// ### pkg/bvm_consts.svh
// Constants for the boost voltage monitor control block
`ifndef BVM_CONSTS_SVH
`define BVM_CONSTS_SVH
`define BVM_ADDR_W 10
`define BVM_DATA_W 16
`define BVM_OFS_SETUP 10'h1C5
`define BVM_OFS_FLAGS 10'h1D2
`define BVM_OFS_THRESH 10'h1C6
`define BVM_SETUP_RESET 16'h0000
`define BVM_THRESH_RESET 8'h7C
`define BVM_BIT_IRQ_EN 0
`define BVM_BIT_UV_MODE 1
`define BVM_BIT_SHUT_EN 2
`define BVM_BIT_UV_FLAG 0
`define BVM_BIT_UV_LIVE 1
`define BVM_BIT_FBK 2
`define BVM_BIT_MODE_RD 3
`define BVM_FILT_CYCLES 4'hF
`define BVM_CNT_W 4
`endif

// ### pkg/bvm_pkg.sv
// Types for the boost voltage monitor control block
package bvm_pkg;
  typedef enum logic [1:0] {
    BVM_MODE_BOOST = 2'b00,
    BVM_MODE_UV = 2'b01
  } bvm_mode_t;
endpackage

// ### verilog/bvm_filter.sv
// Stability filter for the comparator decision
`timescale 1ns/100ps
`include "bvm_consts.svh"
module bvm_filter (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Control
  input wire logic enable,
  input wire logic raw_in,
  // Result
  output logic filt_out
);
  logic [`BVM_CNT_W-1:0] cnt_q;
  logic [`BVM_CNT_W-1:0] cnt_d;
  logic filt_q;
  logic filt_d;
  wire differs = raw_in != filt_q;
  wire settled = cnt_q == `BVM_FILT_CYCLES;
  // When enabled, level changes only after input differs for the full count; when disabled it follows the input
  assign cnt_d = (!enable || !differs) ? '0 : (settled ? cnt_q : cnt_q + 1'b1);
  assign filt_d = !enable ? raw_in : ((differs && settled) ? raw_in : filt_q);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      filt_q <= 1'b1;
    end else begin
      cnt_q <= cnt_d;
      filt_q <= filt_d;
    end
  end
  assign filt_out = filt_q;
endmodule // bvm_filter

// ### verilog/bvm_ctrl.sv
// Boost voltage monitor control and undervoltage logic
`timescale 1ns/100ps
`include "bvm_consts.svh"
// Notes on behaviour
// - Core drives an unsigned eight-bit threshold code to the DAC.
// - Comparator high above threshold, low below; passed to microcores.
// - Threshold equals code times DAC step over divider ratio.
// - Divider select one picks the 1/4 undervoltage ratio.
// - In undervoltage mode the result disables high-side drivers when enabled.
// - In undervoltage mode with shutoff enabled, flag rises once voltage falls below threshold.
// - Comparator result is digitally filtered only in undervoltage mode.
// - Flag ORed with gate and logic supply undervoltage disables drivers.
// - Boost undervoltage event sets status bit in flags register.
// - Flag assertion raises interrupt when boost interrupt enable is set.
module bvm_ctrl (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [`BVM_ADDR_W-1:0] reg_addr,
  input wire logic [`BVM_DATA_W-1:0] reg_wdata,
  output logic [`BVM_DATA_W-1:0] reg_rdata,
  // Analog side
  output logic [7:0] dac_code,
  output logic uv_div_sel,
  input wire logic comp_out,
  // Microcore side
  output logic boost_fbk,
  // Supply monitors
  input wire logic gate_supply_undervoltage,
  input wire logic logic_supply_undervoltage,
  // Driver control and interrupt
  output logic boost_undervoltage_flag,
  output logic hs_predrv_disable,
  output logic irq_req
);
  logic [`BVM_DATA_W-1:0] setup_q;
  logic [7:0] thresh_q;
  logic status_q;
  logic flag_q;
  logic irq_q;
  logic [`BVM_DATA_W-1:0] rdata_q;
  logic [`BVM_DATA_W-1:0] rdata_d;
  logic filt;
  bvm_pkg::bvm_mode_t mode;

  function automatic logic hit(input logic [`BVM_ADDR_W-1:0] a, input logic [`BVM_ADDR_W-1:0] ofs);
    hit = a == ofs;
  endfunction

  wire wr_setup = reg_wr && hit(reg_addr, `BVM_OFS_SETUP);
  wire wr_thresh = reg_wr && hit(reg_addr, `BVM_OFS_THRESH);
  wire rd_flags = reg_rd && hit(reg_addr, `BVM_OFS_FLAGS);
  wire uv_mode = setup_q[`BVM_BIT_UV_MODE];
  wire shut_en = setup_q[`BVM_BIT_SHUT_EN];
  wire irq_en = setup_q[`BVM_BIT_IRQ_EN];
  assign mode = uv_mode ? bvm_pkg::BVM_MODE_UV : bvm_pkg::BVM_MODE_BOOST;

  bvm_filter u_filter (
    .clk(clk),
    .rst_n(rst_n),
    .enable(uv_mode),
    .raw_in(comp_out),
    .filt_out(filt)
  );

  // Undervoltage is a low filtered decision while enabled in undervoltage mode
  wire uv_now = (mode == bvm_pkg::BVM_MODE_UV) && shut_en && !filt;
  wire uv_rise = uv_now && !flag_q;
  wire flags_mode = mode == bvm_pkg::BVM_MODE_UV;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_q <= `BVM_SETUP_RESET;
      thresh_q <= `BVM_THRESH_RESET;
    end else begin
      if (wr_setup) begin
        setup_q <= reg_wdata;
      end
      if (wr_thresh) begin
        thresh_q <= reg_wdata[7:0];
      end
    end
  end

  // Sticky status: a new event wins over the clear-on-read
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      status_q <= 1'b0;
    end else if (uv_rise) begin
      status_q <= 1'b1;
    end else if (rd_flags) begin
      status_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      flag_q <= 1'b0;
      irq_q <= 1'b0;
      rdata_q <= '0;
    end else begin
      flag_q <= uv_now;
      irq_q <= uv_rise && irq_en;
      rdata_q <= rdata_d;
    end
  end

  always_comb begin
    rdata_d = '0;
    if (reg_rd && hit(reg_addr, `BVM_OFS_SETUP)) begin
      rdata_d = setup_q;
    end else if (reg_rd && hit(reg_addr, `BVM_OFS_THRESH)) begin
      rdata_d = {8'h00, thresh_q};
    end else if (rd_flags) begin
      rdata_d[`BVM_BIT_UV_FLAG] = status_q;
      rdata_d[`BVM_BIT_UV_LIVE] = flag_q;
      rdata_d[`BVM_BIT_FBK] = comp_out;
      rdata_d[`BVM_BIT_MODE_RD] = flags_mode;
    end
  end

  assign reg_rdata = rdata_q;
  assign dac_code = thresh_q;
  assign uv_div_sel = uv_mode;
  assign boost_fbk = comp_out;
  assign boost_undervoltage_flag = flag_q;
  assign hs_predrv_disable = flag_q || gate_supply_undervoltage || logic_supply_undervoltage;
  assign irq_req = irq_q;
endmodule // bvm_ctrl

// ### bench/bvm_ctrl_monitor.sv
// Port checker for the boost monitor control block
`timescale 1ns/100ps
`include "bvm_consts.svh"
module bvm_ctrl_monitor (
  // Block ports
  input wire logic clk, rst_n, reg_wr, reg_rd, comp_out, boost_fbk, uv_div_sel, irq_req,
  input wire logic gate_supply_undervoltage, logic_supply_undervoltage, boost_undervoltage_flag, hs_predrv_disable,
  input wire logic [`BVM_ADDR_W-1:0] reg_addr,
  input wire logic [`BVM_DATA_W-1:0] reg_wdata, reg_rdata,
  input wire logic [7:0] dac_code
);
  logic [4:0] lo_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Cycles the comparator has stayed low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) lo_q <= 5'h00;
    else lo_q <= comp_out ? 5'h00 : lo_q + {4'h0, lo_q != 5'h1F};
  end
  a_fbk_pass: assert property (boost_fbk == comp_out) else $error("fbk differs");
  a_predrv_or: assert property (hs_predrv_disable == (boost_undervoltage_flag |
    gate_supply_undervoltage | logic_supply_undervoltage)) else $error("bad disable");
  a_irq_rise: assert property (irq_req |-> boost_undervoltage_flag &&
    !$past(boost_undervoltage_flag)) else $error("irq without rise");
  a_irq_pulse: assert property (irq_req |=> !irq_req) else $error("irq too long");
  a_flag_mode: assert property ($rose(boost_undervoltage_flag) |-> uv_div_sel) else $error("flag in boost");
  a_flag_filt: assert property ($rose(boost_undervoltage_flag) |-> lo_q >= 5'h0F) else $error("unfiltered");
  a_mode_wr: assert property (reg_wr && reg_addr == `BVM_OFS_SETUP |=>
    uv_div_sel == $past(reg_wdata[`BVM_BIT_UV_MODE])) else $error("bad divider");
  a_code_wr: assert property (reg_wr && reg_addr == `BVM_OFS_THRESH |=>
    dac_code == $past(reg_wdata[7:0])) else $error("bad code");
endmodule // bvm_ctrl_monitor
bind bvm_ctrl bvm_ctrl_monitor u_mon (.*);

// ### bench/bvm_analog_model.sv
// Divider, threshold DAC and comparator model
`timescale 1ns/100ps
module bvm_analog_model (
  // Threshold and divider
  input wire logic [7:0] dac_code,
  input wire logic uv_div_sel,
  // Boost pin in mV
  input wire logic [15:0] vb_mv,
  // Decision
  output logic comp_out
);
  // Divided pin in uV against code times 9.77 mV
  assign comp_out = (vb_mv * 1000 / (uv_div_sel ? 4 : 32)) > (dac_code * 9770);
endmodule // bvm_analog_model

// ### bench/bvm_ctrl_bench.sv
// Self-checking bench for the boost monitor control block
`timescale 1ns/100ps
`include "bvm_consts.svh"
module bvm_ctrl_bench;
  logic clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic gate_supply_undervoltage = 1'b0, logic_supply_undervoltage = 1'b0;
  logic [9:0] reg_addr = 10'h000;
  logic [15:0] reg_wdata = 16'h0000, vb_mv = 16'hFDE8, reg_rdata, exp_q[$];
  logic [7:0] dac_code, code;
  logic uv_div_sel, comp_out, boost_fbk, boost_undervoltage_flag, hs_predrv_disable, irq_req;
  int n_fail = 0, total_checks = 0, n_irq = 0;
  bvm_ctrl u_dut (.*);
  bvm_analog_model u_ana (.*);
  always #25 clk = ~clk;
  task chk(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Write, or read noting the expected data
  task acc(input logic wr, input logic [9:0] a, input logic [15:0] d);
    reg_wr = wr; reg_rd = !wr; reg_addr = a; reg_wdata = d;
    if (!wr) exp_q.push_back(d);
    wt(1);
    reg_wr = 1'b0; reg_rd = 1'b0;
    wt(1);
  endtask
  always @(posedge clk) begin
    if (rd_d) chk("rdata", reg_rdata, exp_q.pop_front());
    rd_d = reg_rd;
    n_irq += irq_req;
  end
  task test_done;
    if (n_fail == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #150000; n_fail++; test_done;
  end
  initial begin
    void'($urandom(83429));
    code = 8'h08 + 8'($urandom % 200);
    wt(10); rst_n = 1'b1;
    acc(0, `BVM_OFS_SETUP, `BVM_SETUP_RESET);
    acc(0, 10'h000, 16'h0000);
    chk("dac", {8'h00, dac_code}, {8'h00, `BVM_THRESH_RESET});
    acc(1, `BVM_OFS_THRESH, {8'h00, code});
    vb_mv = 16'(code * 313 + 200); wt(1);
    chk("fbk", 16'(boost_fbk), 16'h0001);
    vb_mv = 16'(code * 312 - 200); wt(30);
    chk("fbk", 16'(boost_fbk), 16'h0000);
    chk("flag", 16'(boost_undervoltage_flag), 16'h0000);
    vb_mv = 16'hFDE8; wt(1);
    acc(1, `BVM_OFS_THRESH, 16'h007C);
    acc(1, `BVM_OFS_SETUP, 16'h0007); wt(20);
    vb_mv = 16'h0FA0; wt(12);
    chk("flag", 16'(boost_undervoltage_flag), 16'h0000);
    for (int i = 0; i < 10 && boost_undervoltage_flag !== 1'b1; i++) wt(1);
    chk("flag", 16'(boost_undervoltage_flag), 16'h0001);
    chk("hs", 16'(hs_predrv_disable), 16'h0001);
    wt(2); acc(0, `BVM_OFS_FLAGS, 16'h000B);
    vb_mv = 16'hFDE8; wt(20);
    acc(0, `BVM_OFS_FLAGS, 16'h000C);
    chk("irq", 16'(n_irq), 16'h0001);
    acc(1, `BVM_OFS_SETUP, 16'h0003);
    vb_mv = 16'h0FA0; wt(25);
    chk("flag", 16'(boost_undervoltage_flag), 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {gate_supply_undervoltage, logic_supply_undervoltage} = 2'($urandom); wt(1);
      chk("hs", 16'(hs_predrv_disable), 16'(gate_supply_undervoltage | logic_supply_undervoltage));
    end
    test_done;
  end
endmodule // bvm_ctrl_bench
